// ==== rtl/uart_frame_formatter.sv ====
`timescale 1ns/10ps
`include "uart_frame_map.svh"

// Notes on behaviour
// - frame opens with one low start bit
// - data bits sent least significant first
// - data length five to eight bits
// - parity or extra bit after data
// - hardware parity even odd mark space
// - one or two high stop bits
// - extra bit off while parity enabled
// - two stop bits only for 6-8 bits
// - multiprocessor mode filters addressed frames
module uart_frame_formatter (
    input  wire logic                  REF_CLK,
    input  wire logic                  RSTN,
    input  wire logic [3:0]            ADDR,
    input  wire uart_frame_pkg::byte_t WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output uart_frame_pkg::byte_t      RDATA,
    input  wire logic                  RXD,
    output logic                       TXD,
    output logic                       IRQ
);
    import uart_frame_pkg::*;

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    byte_t        serial_frame_config;
    logic [15:0]  baud;
    byte_t        node_addr;
    byte_t        status;
    byte_t        mask;
    byte_t        rx_data;
    logic         parity_enable;
    logic         extra_bit_enable;
    logic         stop_two;
    logic         mp_enable;
    parity_t      parity_type;
    logic [3:0]   data_len;
    logic         tx_done_ev;
    logic         rx_ready_ev;
    logic         par_err_ev;
    logic         frm_err_ev;
    logic         ovr_ev;
    logic         tx_busy;
    logic         rx_busy;
    logic         rx_xbit;

    // Decoded frame options
    assign parity_enable    = serial_frame_config[`CFG_PAR_EN];
    assign extra_bit_enable = serial_frame_config[`CFG_XB_EN]
                              && !parity_enable;
    assign data_len = 4'h5 + {2'b00, serial_frame_config[1:0]};
    assign stop_two = serial_frame_config[`CFG_STOP2]
                      && (data_len != 4'h5);
    assign mp_enable   = serial_frame_config[`CFG_MP_EN];
    assign parity_type = parity_t'(serial_frame_config[4:3]);

    // Parity bit for a data word under the selected type
    function automatic logic parity_of(input byte_t d, input logic [3:0] n,
                                       input parity_t t);
        logic x;
        x = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n) begin
                x = x ^ d[i];
            end
        end
        case (t)
            PAR_ODD:  parity_of = ~x;
            PAR_EVEN: parity_of = x;
            PAR_MARK: parity_of = 1'b1;
            default:  parity_of = 1'b0;
        endcase
    endfunction : parity_of

    // Software writes to configuration
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            serial_frame_config <= `CFG_RESET;
            baud                <= `BAUD_RESET;
            node_addr           <= `ADDR_RESET;
            mask                <= 8'h00;
        end else if (WR) begin
            if (ADDR == `REG_CONFIG) begin
                serial_frame_config <= WDATA;
            end else if (ADDR == `REG_BAUD) begin
                baud <= {WDATA, 8'h00} | 16'h0010;
            end else if (ADDR == `REG_MASK) begin
                mask <= WDATA;
            end else if (ADDR == `REG_ADDR) begin
                node_addr <= WDATA;
            end
        end
    end

    // -----------------------------------------------------------
    // Transmitter
    // -----------------------------------------------------------
    frame_state_t tx_state;
    byte_t        tx_shift;
    logic [3:0]   tx_count;
    logic         tx_extra;
    logic         tx_tick;
    logic         tx_start;
    logic         tx_xbit_cfg;

    assign tx_start    = WR && (ADDR == `REG_TXDATA) && !tx_busy;
    assign tx_busy     = (tx_state != S_IDLE);
    // Extra bit value for sends comes from the multiprocessor bit
    assign tx_xbit_cfg = mp_enable;

    uart_bit_timer u_tx_timer (
        .REF_CLK   (REF_CLK),
        .RSTN      (RSTN),
        .restart   (tx_start),
        .divisor   (baud),
        .half_tick (),
        .full_tick (tx_tick)
    );

    // Transmit sequence
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            tx_state <= S_IDLE;
            tx_shift <= 8'h00;
            tx_count <= 4'h0;
            tx_extra <= 1'b0;
            TXD      <= 1'b1;
        end else begin
            case (tx_state)
                S_IDLE: begin
                    TXD <= 1'b1;
                    if (tx_start) begin
                        tx_shift <= WDATA;
                        tx_extra <= parity_enable
                            ? parity_of(WDATA, data_len, parity_type)
                            : tx_xbit_cfg;
                        TXD      <= 1'b0;
                        tx_state <= S_START;
                    end
                end
                S_START: if (tx_tick) begin
                    TXD      <= tx_shift[0];
                    tx_shift <= {1'b0, tx_shift[7:1]};
                    tx_count <= 4'h1;
                    tx_state <= S_DATA;
                end
                S_DATA: if (tx_tick) begin
                    if (tx_count < data_len) begin
                        TXD      <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_count <= tx_count + 4'h1;
                    end else if (parity_enable || extra_bit_enable) begin
                        TXD      <= tx_extra;
                        tx_state <= S_EXTRA;
                    end else begin
                        TXD      <= 1'b1;
                        tx_state <= S_STOP1;
                    end
                end
                S_EXTRA: if (tx_tick) begin
                    TXD      <= 1'b1;
                    tx_state <= S_STOP1;
                end
                S_STOP1: if (tx_tick) begin
                    tx_state <= stop_two ? S_STOP2 : S_IDLE;
                end
                default: if (tx_tick) begin
                    tx_state <= S_IDLE;
                end
            endcase
        end
    end

    assign tx_done_ev = tx_tick && ((tx_state == S_STOP2)
                        || (tx_state == S_STOP1 && !stop_two));

    // -----------------------------------------------------------
    // Receiver
    // -----------------------------------------------------------
    logic         rxd_meta;
    logic         rxd_sync;
    logic         rxd_last;
    frame_state_t rx_state;
    byte_t        rx_shift;
    logic [3:0]   rx_count;
    logic         rx_par;
    logic         rx_half;
    logic         rx_fall;
    logic         rx_accept;

    // Two-stage synchroniser for the line
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            rxd_last <= 1'b1;
        end else begin
            rxd_meta <= RXD;
            rxd_sync <= rxd_meta;
            rxd_last <= rxd_sync;
        end
    end

    assign rx_fall = (rx_state == S_IDLE) && rxd_last && !rxd_sync;
    assign rx_busy = (rx_state != S_IDLE);

    uart_bit_timer u_rx_timer (
        .REF_CLK   (REF_CLK),
        .RSTN      (RSTN),
        .restart   (rx_fall),
        .divisor   (baud),
        .half_tick (rx_half),
        .full_tick ()
    );

    // Receive sequence, sampling at mid-bit
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            rx_state <= S_IDLE;
            rx_shift <= 8'h00;
            rx_count <= 4'h0;
            rx_par   <= 1'b0;
        end else begin
            case (rx_state)
                S_IDLE: if (rx_fall) begin
                    rx_state <= S_START;
                end
                S_START: if (rx_half) begin
                    // False start if line is high again mid-bit
                    rx_state <= rxd_sync ? S_IDLE : S_DATA;
                    rx_count <= 4'h0;
                    rx_shift <= 8'h00;
                end
                S_DATA: if (rx_half) begin
                    rx_shift[rx_count[2:0]] <= rxd_sync;
                    rx_count <= rx_count + 4'h1;
                    if (rx_count + 4'h1 == data_len) begin
                        rx_state <= (parity_enable || extra_bit_enable)
                                    ? S_EXTRA : S_STOP1;
                    end
                end
                S_EXTRA: if (rx_half) begin
                    rx_par   <= rxd_sync;
                    rx_state <= S_STOP1;
                end
                S_STOP1: if (rx_half) begin
                    rx_state <= S_IDLE;
                end
                default: rx_state <= S_IDLE;
            endcase
        end
    end

    // Frame end events; multiprocessor mode keeps only address frames
    // with a matching address, or data while addressed
    logic addressed;
    logic rx_end;
    assign rx_end    = (rx_state == S_STOP1) && rx_half;
    assign rx_accept = rx_end && (!mp_enable
                       || (rx_par && rx_shift == node_addr)
                       || (!rx_par && addressed));

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            addressed <= 1'b0;
        end else if (rx_end && mp_enable && rx_par) begin
            addressed <= (rx_shift == node_addr);
        end
    end

    assign rx_ready_ev = rx_accept;
    assign par_err_ev  = rx_accept && parity_enable
        && (rx_par != parity_of(rx_shift, data_len, parity_type));
    assign frm_err_ev  = rx_end && !rxd_sync;
    assign ovr_ev      = rx_accept && status[`ST_RX_READY];

    // Received word and its extra bit
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            rx_data <= 8'h00;
            rx_xbit <= 1'b0;
        end else if (rx_accept) begin
            rx_data <= rx_shift;
            rx_xbit <= rx_par;
        end
    end

    // -----------------------------------------------------------
    // Status and interrupt; set wins over read clear
    // -----------------------------------------------------------
    byte_t events;
    assign events = {3'b000, ovr_ev, frm_err_ev, par_err_ev,
                     rx_ready_ev, tx_done_ev};

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            status <= 8'h00;
        end else if (RD && ADDR == `REG_STATUS) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    assign IRQ = |(status[4:0] & mask[4:0]);

    // Read data, one cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            if (ADDR == `REG_CONFIG) begin
                RDATA <= serial_frame_config;
            end else if (ADDR == `REG_BAUD) begin
                RDATA <= baud[15:8];
            end else if (ADDR == `REG_RXDATA) begin
                RDATA <= rx_data;
            end else if (ADDR == `REG_STATUS) begin
                RDATA <= {rx_xbit, rx_busy, tx_busy, status[4:0]};
            end else if (ADDR == `REG_MASK) begin
                RDATA <= mask;
            end else if (ADDR == `REG_ADDR) begin
                RDATA <= node_addr;
            end else begin
                RDATA <= 8'h00;
            end
        end else begin
            RDATA <= 8'h00;
        end
    end

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    a_start_low: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        tx_start |=> !TXD)
        else $error("start bit not low");
    a_first_lsb: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (tx_state == S_START && tx_tick) |=> TXD == $past(tx_shift[0]))
        else $error("first data bit not lsb");
    a_len_range: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        data_len >= 4'h5 && data_len <= 4'h8)
        else $error("data length out of range");
    a_extra_slot: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (tx_state == S_DATA && tx_tick && tx_count == data_len
         && parity_enable) |=> tx_state == S_EXTRA)
        else $error("parity slot skipped");
    a_stop_high: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (tx_state == S_STOP1 || tx_state == S_STOP2) |-> TXD)
        else $error("stop bit low");
    a_no_xb_par: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        parity_enable |-> !extra_bit_enable)
        else $error("extra bit with parity");
    a_stop_five: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        tx_state == S_STOP2 |-> $past(data_len) != 4'h5)
        else $error("two stops for five bits");
    a_frm_flag: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        frm_err_ev |=> status[`ST_FRM_ERR])
        else $error("framing error lost");
endmodule : uart_frame_formatter

// ==== rtl/uart_frame_map.svh ====
`ifndef UART_FRAME_MAP_SVH
`define UART_FRAME_MAP_SVH

// Register word offsets on the plain register port
`define REG_CONFIG      4'h0
`define REG_BAUD        4'h1
`define REG_TXDATA      4'h2
`define REG_RXDATA      4'h3
`define REG_STATUS      4'h4
`define REG_MASK        4'h5
`define REG_ADDR        4'h6

// Frame configuration field positions
`define CFG_LEN_LO      0
`define CFG_LEN_HI      1
`define CFG_PAR_EN      2
`define CFG_PAR_LO      3
`define CFG_PAR_HI      4
`define CFG_XB_EN       5
`define CFG_STOP2       6
`define CFG_MP_EN       7
`define CFG_RESET       8'h03

// Status bit positions
`define ST_TX_DONE      0
`define ST_RX_READY     1
`define ST_PAR_ERR      2
`define ST_FRM_ERR      3
`define ST_OVERRUN      4
`define ST_TX_BUSY      5
`define ST_RX_BUSY      6
`define ST_RX_XBIT      7

// Baud divisor: clock cycles per bit, reset value
`define BAUD_RESET      16'h01b2
`define ADDR_RESET      8'h00

`endif

// ==== rtl/uart_frame_pkg.sv ====
package uart_frame_pkg;
    typedef enum logic [1:0] {
        PAR_ODD,
        PAR_EVEN,
        PAR_MARK,
        PAR_SPACE
    } parity_t;

    typedef enum {
        S_IDLE,
        S_START,
        S_DATA,
        S_EXTRA,
        S_STOP1,
        S_STOP2
    } frame_state_t;

    typedef logic [7:0] byte_t;
endpackage : uart_frame_pkg

// ==== rtl/uart_bit_timer.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Bit timer: counts one bit time, pulses at the half and the end
// ---------------------------------------------------------------
module uart_bit_timer (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        restart,
    input  wire logic [15:0] divisor,
    output logic             half_tick,
    output logic             full_tick
);
    logic [15:0] count;

    // Free count, restarted at each frame edge
    always_ff @(posedge REF_CLK) begin
        if (!RSTN || restart) begin
            count <= 16'h0000;
        end else if (count >= divisor - 16'h0001) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end

    assign half_tick = !restart && (count == {1'b0, divisor[15:1]});
    assign full_tick = !restart && (count >= divisor - 16'h0001);
endmodule : uart_bit_timer

// ==== testbench/uart_remote_node.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Remote node: drives frames onto the receive line
// ---------------------------------------------------------------
module uart_remote_node #(
    parameter int BIT_CYC = 16
) (
    input  wire logic ref_clk,
    output logic      line_out
);
    // Idle-high line between frames
    initial line_out = 1'b1;

    // Holds the line for one bit time
    task automatic put_bit(input logic b);
        line_out <= b;
        repeat (BIT_CYC) @(posedge ref_clk);
    endtask : put_bit

    // One frame; gap stretches the idle time for a slow node
    task automatic send(input logic [7:0] data, input int nbits,
                        input logic has_x, input logic xval,
                        input logic stop_val, input int gap);
        repeat (gap + 1) @(posedge ref_clk);
        put_bit(1'b0);
        for (int i = 0; i < nbits; i++) begin
            put_bit(data[i]);
        end
        if (has_x) begin
            put_bit(xval);
        end
        put_bit(stop_val);
        line_out <= 1'b1;
    endtask : send
endmodule : uart_remote_node

// ==== testbench/tb_uart_frame_formatter.sv ====
`timescale 1ns/10ps
`include "uart_frame_map.svh"
module tb_uart_frame_formatter;
    import uart_frame_pkg::*;
    localparam int BIT_CYC = 16;    // Divisor after a baud write of zero
    typedef struct { byte_t cfg; byte_t d; int nb; } row_t;
    logic        REF_CLK = 1'b0;
    logic        RSTN    = 1'b0;
    logic [3:0]  ADDR    = 4'h0;
    byte_t       WDATA   = 8'h00;
    logic        WR      = 1'b0;
    logic        RD      = 1'b0;
    byte_t       RDATA;
    logic        RXD;
    logic        TXD;
    logic        IRQ;
    int          failures = 0;
    int          checked  = 0;
    byte_t       rv;
    row_t        rows [12] = '{
        '{8'h03, 8'ha5, 10}, '{8'h00, 8'h1b, 7},  '{8'h40, 8'h15, 7},
        '{8'h41, 8'h2c, 9},  '{8'h06, 8'h35, 10}, '{8'h0f, 8'h81, 11},
        '{8'h17, 8'h00, 11}, '{8'h1f, 8'hff, 11}, '{8'h23, 8'h5c, 11},
        '{8'ha3, 8'h5c, 11}, '{8'h27, 8'h96, 11}, '{8'h42, 8'h0f, 10}};

    always #10 REF_CLK = ~REF_CLK;

    uart_frame_formatter uart_frame_formatter_i (
        .REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
    uart_remote_node #(.BIT_CYC(BIT_CYC)) uart_remote_node_i (
        .ref_clk(REF_CLK), .line_out(RXD));

    // ---------------------------------------------------------------
    // Checking, bus cycles and reference frame
    // ---------------------------------------------------------------
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [3:0] a, input byte_t d);
        @(posedge REF_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge REF_CLK);
        WR    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output byte_t d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge REF_CLK);
        RD   <= 1'b0;
        #1 d = RDATA;
    endtask : rd

    task automatic reset_dut();
        RSTN <= 1'b0;
        repeat (20) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
    endtask : reset_dut

    // Expected line levels in time order, start bit at index 0
    function automatic logic [11:0] frame_of(byte_t cfg, byte_t d);
        int          len;
        int          n;
        logic        p;
        logic [11:0] f;
        len = 5 + int'(cfg[1:0]);
        f = '0;
        for (int i = 0; i < len; i++) f[i + 1] = d[i];
        n = len + 1;
        if (cfg[`CFG_PAR_EN]) begin
            case (parity_t'(cfg[4:3]))
                PAR_ODD:  p = ~^f;
                PAR_EVEN: p = ^f;
                PAR_MARK: p = 1'b1;
                default:  p = 1'b0;
            endcase
            f[n] = p;
            n++;
        end else if (cfg[`CFG_XB_EN]) begin
            f[n] = cfg[`CFG_MP_EN];
            n++;
        end
        f[n] = 1'b1;
        if (cfg[`CFG_STOP2] && len > 5) f[n + 1] = 1'b1;
        return f;
    endfunction : frame_of

    // Sends one byte, a refused second write, and samples the frame
    task automatic tx_row(input row_t r);
        int          k;
        logic [11:0] seen;
        wr(`REG_CONFIG, r.cfg);
        wr(`REG_TXDATA, r.d);
        wr(`REG_TXDATA, ~r.d);
        #1 k = 0;
        while (TXD !== 1'b0 && k < 40) begin
            @(posedge REF_CLK);
            #1 k++;
        end
        if (k == 40) begin
            failures++;
            report_and_stop();
        end
        seen = '0;
        for (int i = 0; i < r.nb; i++) begin
            repeat (i == 0 ? 6 : BIT_CYC) @(posedge REF_CLK);
            #1 seen[i] = TXD;
        end
        chk(seen, frame_of(r.cfg, r.d));
        chk({11'h0, IRQ}, 12'h000);
        k = 0;
        while (IRQ !== 1'b1 && k < 12) begin
            @(posedge REF_CLK);
            #1 k++;
        end
        chk({11'h0, IRQ}, 12'h001);
        rd(`REG_STATUS, rv);
    endtask : tx_row

    // ---------------------------------------------------------------
    // Watchdog against a hung run
    // ---------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge REF_CLK);
        failures++;
        report_and_stop();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        reset_dut();
        chk({10'h0, TXD, IRQ}, 12'h002);
        wr(`REG_BAUD, 8'h00);
        wr(`REG_MASK, 8'h01);
        foreach (rows[i]) tx_row(rows[i]);
        // Second reset in mid-run, then reset values and unmapped read
        reset_dut();
        rd(`REG_CONFIG, rv);
        chk(rv, 8'h03);
        rd(`REG_BAUD, rv);
        chk(rv, 8'h01);
        rd(`REG_MASK, rv);
        chk(rv, 8'h00);
        rd(`REG_ADDR, rv);
        chk(rv, 8'h00);
        rd(4'hf, rv);
        chk(rv, 8'h00);
        wr(`REG_BAUD, 8'h00);
        // Plain receive with every event masked
        uart_remote_node_i.send(8'h5a, 8, 1'b0, 1'b0, 1'b1, 0);
        chk({11'h0, IRQ}, 12'h000);
        rd(`REG_STATUS, rv);
        chk(rv & 8'h1f, 8'h02);
        rd(`REG_RXDATA, rv);
        chk(rv, 8'h5a);
        // Bad parity from a slow node raises the interrupt
        wr(`REG_MASK, 8'h0c);
        wr(`REG_CONFIG, 8'h07);
        uart_remote_node_i.send(8'h5a, 8, 1'b1, ^8'h5a, 1'b1, 5);
        chk({11'h0, IRQ}, 12'h001);
        rd(`REG_STATUS, rv);
        chk(rv & 8'h0c, 8'h04);
        chk({11'h0, IRQ}, 12'h000);
        // Low stop bit with good parity
        uart_remote_node_i.send(8'h33, 8, 1'b1, ~^8'h33, 1'b0, 0);
        rd(`REG_STATUS, rv);
        chk(rv & 8'h0c, 8'h08);
        // Multiprocessor: data ignored until the node is addressed
        wr(`REG_ADDR, 8'h12);
        wr(`REG_CONFIG, 8'ha3);            // Extra bit carries the address mark
        uart_remote_node_i.send(8'h77, 8, 1'b1, 1'b0, 1'b1, 4);
        rd(`REG_STATUS, rv);
        chk(rv & 8'h02, 8'h00);
        uart_remote_node_i.send(8'h12, 8, 1'b1, 1'b1, 1'b1, 4);
        rd(`REG_STATUS, rv);
        uart_remote_node_i.send(8'h3c, 8, 1'b1, 1'b0, 1'b1, 4);
        rd(`REG_STATUS, rv);
        chk(rv & 8'h02, 8'h02);
        rd(`REG_RXDATA, rv);
        chk(rv, 8'h3c);
        report_and_stop();
    end
endmodule : tb_uart_frame_formatter
